// *** inc/ppamux_map.vh ***
// pin positions, port widths and reset values for the port pin mux
`ifndef PPAMUX_MAP_VH
`define PPAMUX_MAP_VH

// ----------------------------------------
// port widths
// ----------------------------------------
`define PPAMUX_PORTB_W 6
`define PPAMUX_PORTD_W 8

// ----------------------------------------
// port b alternate pin positions
// ----------------------------------------
`define PPAMUX_PB_SCK 5
`define PPAMUX_PB_MISO 4
`define PPAMUX_PB_MOSI 3
`define PPAMUX_PB_SEL 2
`define PPAMUX_PB_CMP 1
`define PPAMUX_PB_CAP 0

// ----------------------------------------
// port d alternate pin positions
// ----------------------------------------
`define PPAMUX_PD_CNEG 7
`define PPAMUX_PD_CPOS 6
`define PPAMUX_PD_CNT1 5
`define PPAMUX_PD_CNT0 4
`define PPAMUX_PD_IRQ1 3
`define PPAMUX_PD_IRQ0 2
`define PPAMUX_PD_TXD 1
`define PPAMUX_PD_RXD 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define PPAMUX_PORTB_RST 6'h00
`define PPAMUX_PORTD_RST 8'h00
`define PPAMUX_BIT_RST 1'h0
`define PPAMUX_SEL_RST 1'h1

`endif

// *** rtl/ppamux_top.v ***
// direction, pull-up and alternate function mux for port b and port d pins
//
// Overview of operation
// [R1] spi master forces miso pin input; as slave its direction bit decides
// [R2] a pin forced to input still takes its pull-up from its value bit
// [R3] spi slave forces mosi pin input; as master its direction bit decides
// [R4] spi slave forces select pin input; as master its direction bit decides
// [R5] spi slave is active only while select pin is low; master drives it
// [R6] timer-1 compare output reaches port b bit 1 only when set as output
// [R7] port b bit 0 is capture source, valid only when set as input
// [R8] port d: dir 0 val 0 hi-z, dir 0 val 1 pull-up, dir 1 drives value
// [R9] port d bit 7 is comparator negative, valid when input without pull-up
// [R10] port d bit 6 is comparator positive, valid when input without pull-up
// [R11] power-down cuts the digital input path of both comparator pins
// [R12] uart transmitter enabled forces port d bit 1 output with transmit data
// [R13] uart receiver enabled forces port d bit 0 input feeding the receiver
// [R14] forced receive pin gets pull-up when its value bit is one
// [R15] port d bit 3 feeds external interrupt one, bit 2 interrupt zero
// [R16] port d bit 5 counts timer 1, port d bit 4 counts timer 0
// [R17] every pin input is synchronised to the clock before use
// [R18] spi slave forces clock pin input; as master its direction bit decides
// [R19] port b: dir 0 val 0 hi-z, dir 0 val 1 pull-up, dir 1 drives value
// [R20] all pins tri-state at once when reset asserts, clock or not
// [R21] without override, software bits rule; overrides win when they apply
`timescale 1ns/100ps
`include "ppamux_map.vh"

module ppamux_top (
  // ----------------------------------------
  // clock and reset
  // ----------------------------------------
  input wire clk,
  input wire rstn,
  // ----------------------------------------
  // software direction and value bits
  // ----------------------------------------
  input wire [5:0] portb_dir_bit,
  input wire [5:0] portb_value_bit,
  input wire [7:0] portd_dir_bit,
  input wire [7:0] portd_value_bit,
  // ----------------------------------------
  // peripheral roles and drive data
  // ----------------------------------------
  input wire spi_enable,
  input wire spi_master,
  input wire spi_sck_drive,
  input wire spi_mosi_drive,
  input wire spi_miso_drive,
  input wire compare_match_enable,
  input wire compare_match_out,
  input wire uart_tx_enable,
  input wire uart_tx_data,
  input wire uart_rx_enable,
  input wire power_down,
  // ----------------------------------------
  // pin levels
  // ----------------------------------------
  input wire [5:0] portb_pin_in,
  input wire [7:0] portd_pin_in,
  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  output reg [5:0] portb_pin_out,
  output reg [5:0] portb_pin_oe,
  output reg [5:0] portb_pullup,
  output reg [7:0] portd_pin_out,
  output reg [7:0] portd_pin_oe,
  output reg [7:0] portd_pullup,
  // ----------------------------------------
  // synchronised pin levels
  // ----------------------------------------
  output wire [5:0] portb_sync_in,
  output wire [7:0] portd_sync_in,
  // ----------------------------------------
  // alternate function inputs
  // ----------------------------------------
  output reg spi_sck_in,
  output reg spi_mosi_in,
  output reg spi_miso_in,
  output reg spi_slave_active,
  output reg capture_in,
  output reg capture_valid,
  output reg comparator_neg_valid,
  output reg comparator_pos_valid,
  output reg counter1_ext_source,
  output reg counter0_ext_source,
  output reg ext_irq_one,
  output reg ext_irq_zero,
  output reg uart_rx_data
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // pull-up is on only for an input pin whose value bit is one
  function pull_on;
    input oe;
    input val;
    begin
      pull_on = ~oe & val;
    end
  endfunction

  // comparator pin is usable only as an input without pull-up
  function analog_ok;
    input dir;
    input val;
    begin
      analog_ok = ~dir & ~val;
    end
  endfunction

  // ----------------------------------------
  // role decode
  // ----------------------------------------
  wire spi_is_master;
  wire spi_is_slave;
  wire pb_cmp_drive;
  assign spi_is_master = spi_enable & spi_master;
  assign spi_is_slave = spi_enable & ~spi_master;
  // compare output only when the pin is already an output
  assign pb_cmp_drive = compare_match_enable & portb_dir_bit[`PPAMUX_PB_CMP]; // R6

  // ----------------------------------------
  // port b direction, value and pull-up
  // ----------------------------------------
  reg [5:0] pb_oe_next;
  reg [5:0] pb_out_next;
  reg [5:0] pb_pull_next;
  integer ib;

  always @* begin
    pb_oe_next = portb_dir_bit; // R19 R21
    pb_out_next = portb_value_bit; // R19
    // serial clock: slave forces input, master output carries the clock
    if (spi_is_slave) begin
      pb_oe_next[`PPAMUX_PB_SCK] = 1'b0; // R18
    end else if (spi_is_master) begin
      pb_out_next[`PPAMUX_PB_SCK] = spi_sck_drive;
    end
    // master-in pin: master forces input, slave follows direction bit
    if (spi_is_master) begin
      pb_oe_next[`PPAMUX_PB_MISO] = 1'b0; // R1
    end else if (spi_is_slave) begin
      pb_out_next[`PPAMUX_PB_MISO] = spi_miso_drive;
    end
    // master-out pin: slave forces input, master follows direction bit
    if (spi_is_slave) begin
      pb_oe_next[`PPAMUX_PB_MOSI] = 1'b0; // R3
    end else if (spi_is_master) begin
      pb_out_next[`PPAMUX_PB_MOSI] = spi_mosi_drive;
    end
    // select pin: slave forces input; master keeps plain port use
    if (spi_is_slave) begin
      pb_oe_next[`PPAMUX_PB_SEL] = 1'b0; // R4
    end
    if (pb_cmp_drive) begin
      pb_out_next[`PPAMUX_PB_CMP] = compare_match_out; // R6
    end
    for (ib = 0; ib < `PPAMUX_PORTB_W; ib = ib + 1) begin
      // forced inputs keep value-bit control of the pull-up
      pb_pull_next[ib] = pull_on(pb_oe_next[ib], portb_value_bit[ib]); // R2 R19
    end
  end

  // ----------------------------------------
  // port d direction, value and pull-up
  // ----------------------------------------
  reg [7:0] pd_oe_next;
  reg [7:0] pd_out_next;
  reg [7:0] pd_pull_next;
  integer id;

  always @* begin
    pd_oe_next = portd_dir_bit; // R8 R21
    pd_out_next = portd_value_bit; // R8
    if (uart_tx_enable) begin
      pd_oe_next[`PPAMUX_PD_TXD] = 1'b1; // R12
      pd_out_next[`PPAMUX_PD_TXD] = uart_tx_data; // R12
    end
    if (uart_rx_enable) begin
      pd_oe_next[`PPAMUX_PD_RXD] = 1'b0; // R13
    end
    for (id = 0; id < `PPAMUX_PORTD_W; id = id + 1) begin
      // receive pin forced to input still honours its value bit
      pd_pull_next[id] = pull_on(pd_oe_next[id], portd_value_bit[id]); // R8 R14
    end
  end

  // ----------------------------------------
  // pin drive registers
  // ----------------------------------------
  // async clear releases every pin even with the clock stopped
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      portb_pin_oe <= `PPAMUX_PORTB_RST; // R20
      portb_pin_out <= `PPAMUX_PORTB_RST;
      portb_pullup <= `PPAMUX_PORTB_RST; // R20
      portd_pin_oe <= `PPAMUX_PORTD_RST; // R20
      portd_pin_out <= `PPAMUX_PORTD_RST;
      portd_pullup <= `PPAMUX_PORTD_RST; // R20
    end else begin
      portb_pin_oe <= pb_oe_next;
      portb_pin_out <= pb_out_next;
      portb_pullup <= pb_pull_next;
      portd_pin_oe <= pd_oe_next;
      portd_pin_out <= pd_out_next;
      portd_pullup <= pd_pull_next;
    end
  end

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  // comparator pins are cut ahead of the first stage in power-down so a
  // mid-rail analog level never toggles digital logic
  wire [7:0] pd_pin_gated;
  genvar gg;
  generate
    for (gg = 0; gg < `PPAMUX_PORTD_W; gg = gg + 1) begin : g_pd_gate
      if (gg == `PPAMUX_PD_CNEG || gg == `PPAMUX_PD_CPOS) begin : g_cut
        assign pd_pin_gated[gg] = portd_pin_in[gg] & ~power_down; // R11
      end else begin : g_pass
        assign pd_pin_gated[gg] = portd_pin_in[gg];
      end
    end
  endgenerate

  reg [5:0] pb_meta_reg;
  reg [5:0] pb_sync_reg;
  reg [7:0] pd_meta_reg;
  reg [7:0] pd_sync_reg;

  genvar gb;
  generate
    for (gb = 0; gb < `PPAMUX_PORTB_W; gb = gb + 1) begin : g_pb_sync
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          pb_meta_reg[gb] <= `PPAMUX_BIT_RST;
          pb_sync_reg[gb] <= `PPAMUX_BIT_RST;
        end else begin
          pb_meta_reg[gb] <= portb_pin_in[gb]; // R17
          pb_sync_reg[gb] <= pb_meta_reg[gb]; // R17
        end
      end
    end
  endgenerate

  genvar gd;
  generate
    for (gd = 0; gd < `PPAMUX_PORTD_W; gd = gd + 1) begin : g_pd_sync
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          pd_meta_reg[gd] <= `PPAMUX_BIT_RST;
          pd_sync_reg[gd] <= `PPAMUX_BIT_RST;
        end else begin
          pd_meta_reg[gd] <= pd_pin_gated[gd]; // R17
          pd_sync_reg[gd] <= pd_meta_reg[gd]; // R17
        end
      end
    end
  endgenerate

  assign portb_sync_in = pb_sync_reg;
  assign portd_sync_in = pd_sync_reg;

  // ----------------------------------------
  // alternate input routing
  // ----------------------------------------
  // receiver sees idle-high while disabled so it cannot false-start
  wire rx_pin_seen;
  assign rx_pin_seen = uart_rx_enable ? pd_sync_reg[`PPAMUX_PD_RXD] : 1'b1; // R13

  // one extra stage keeps every alternate output straight from a flop;
  // the cost is one more cycle of input latency
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      spi_sck_in <= `PPAMUX_BIT_RST;
      spi_mosi_in <= `PPAMUX_BIT_RST;
      spi_miso_in <= `PPAMUX_BIT_RST;
      spi_slave_active <= `PPAMUX_BIT_RST;
      capture_in <= `PPAMUX_BIT_RST;
      capture_valid <= `PPAMUX_BIT_RST;
      comparator_neg_valid <= `PPAMUX_BIT_RST;
      comparator_pos_valid <= `PPAMUX_BIT_RST;
      counter1_ext_source <= `PPAMUX_BIT_RST;
      counter0_ext_source <= `PPAMUX_BIT_RST;
      ext_irq_one <= `PPAMUX_BIT_RST;
      ext_irq_zero <= `PPAMUX_BIT_RST;
      uart_rx_data <= `PPAMUX_SEL_RST;
    end else begin
      spi_sck_in <= pb_sync_reg[`PPAMUX_PB_SCK];
      spi_mosi_in <= pb_sync_reg[`PPAMUX_PB_MOSI];
      spi_miso_in <= pb_sync_reg[`PPAMUX_PB_MISO];
      // slave engine runs only while the external master holds select low
      spi_slave_active <= spi_is_slave & ~pb_sync_reg[`PPAMUX_PB_SEL]; // R5
      capture_in <= pb_sync_reg[`PPAMUX_PB_CAP]; // R7
      capture_valid <= ~portb_dir_bit[`PPAMUX_PB_CAP]; // R7
      comparator_neg_valid <= analog_ok(portd_dir_bit[`PPAMUX_PD_CNEG], // R9
                                        portd_value_bit[`PPAMUX_PD_CNEG]);
      comparator_pos_valid <= analog_ok(portd_dir_bit[`PPAMUX_PD_CPOS], // R10
                                        portd_value_bit[`PPAMUX_PD_CPOS]);
      counter1_ext_source <= pd_sync_reg[`PPAMUX_PD_CNT1]; // R16
      counter0_ext_source <= pd_sync_reg[`PPAMUX_PD_CNT0]; // R16
      ext_irq_one <= pd_sync_reg[`PPAMUX_PD_IRQ1]; // R15
      ext_irq_zero <= pd_sync_reg[`PPAMUX_PD_IRQ0]; // R15
      uart_rx_data <= rx_pin_seen; // R13
    end
  end

endmodule

// *** dv/ppamux_asserts.sv ***
// concurrent checks on the port pin mux ports
`timescale 1ns/100ps
module ppamux_asserts (
  input wire clk, rstn, spi_enable, spi_master, compare_match_enable, compare_match_out,
  input wire uart_tx_enable, uart_tx_data, uart_rx_enable, power_down, spi_slave_active,
  input wire capture_in, ext_irq_one, ext_irq_zero, counter1_ext_source, counter0_ext_source,
  input wire [5:0] portb_dir_bit, portb_value_bit, portb_pin_in, portb_pin_out, portb_pin_oe,
  input wire [5:0] portb_pullup,
  input wire [7:0] portd_dir_bit, portd_value_bit, portd_pin_in, portd_pin_oe, portd_pin_out,
  input wire [7:0] portd_pullup, portd_sync_in
);
  reg rst_done_reg;
  // the first edge after release still shows reset values, so checks start one edge later
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_done_reg <= 1'b0;
    end else begin
      rst_done_reg <= 1'b1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn || !rst_done_reg);
  a_miso_forced: assert property (spi_enable && spi_master |=> !portb_pin_oe[4])
    else $error("miso pin driven in master role");
  a_pullup_value: assert property (1 |=>
    portb_pullup == (~portb_pin_oe & $past(portb_value_bit)))
    else $error("port b pull-up wrong");
  a_slave_inputs: assert property (spi_enable && !spi_master |=>
    (portb_pin_oe & 6'h2c) == 6'h00)
    else $error("slave input pin driven");
  a_cmp_drive: assert property (compare_match_enable && portb_dir_bit[1] |=>
    portb_pin_oe[1] && portb_pin_out[1] == $past(compare_match_out))
    else $error("compare output missing");
  a_capture_path: assert property (1 |-> ##3 capture_in == $past(portb_pin_in[0], 3))
    else $error("capture path latency wrong");
  a_pd_gate: assert property (power_down |=> ##1 portd_sync_in[7:6] == 2'h0)
    else $error("comparator pins not gated");
  a_tx_force: assert property (uart_tx_enable |=>
    portd_pin_oe[1] && portd_pin_out[1] == $past(uart_tx_data))
    else $error("transmit pin not forced");
  a_rx_force: assert property (uart_rx_enable |=>
    !portd_pin_oe[0] && portd_pullup[0] == $past(portd_value_bit[0]))
    else $error("receive pin not forced");
  a_portd_plain: assert property (!uart_tx_enable && !uart_rx_enable |=>
    portd_pin_oe == $past(portd_dir_bit))
    else $error("port d direction wrong");
  a_irq_route: assert property (1 |-> ##3
    {counter1_ext_source, counter0_ext_source, ext_irq_one, ext_irq_zero} ==
    $past(portd_pin_in[5:2], 3))
    else $error("port d routing wrong");
  a_slave_select: assert property (spi_slave_active |-> $past(spi_enable) && !$past(spi_master))
    else $error("slave active outside slave role");
  cover property (spi_slave_active);
  cover property (uart_tx_enable && uart_rx_enable);
  cover property (power_down && compare_match_enable);
endmodule
bind ppamux_top ppamux_asserts u_chk (.*);

// *** dv/ppamux_board.sv ***
// board model: drives or releases the port pins
`timescale 1ns/100ps
module ppamux_board #(parameter W = 8) (
  input wire [W-1:0] oe,
  input wire [W-1:0] out,
  input wire [W-1:0] pu,
  input wire [W-1:0] ext,
  input wire [W-1:0] ext_en,
  output wire [W-1:0] level
);
  // a floating line without pull-up shows the inverse of its random ext bit
  assign level = (oe & out) | (~oe & ext_en & ext) | (~oe & ~ext_en & (pu | ~ext));
endmodule

// *** dv/tb_top.sv ***
// random self-checking bench for the port pin mux
`timescale 1ns/100ps
module tb_top;
  reg clk, rstn, s, m;
  reg [5:0] bdir, bval, bext, ben, xbo, xbv, xbp, hb0, hb1;
  reg [7:0] ddir, dval, dext, den, xdo, xdv, xdp, hd0, hd1, t8;
  reg [10:0] c;
  reg [31:0] r;
  integer run, cyc, fail_count, n_tests;
  logic [63:0] qd[$], qs[$], qa[$];
  logic [63:0] ed;
  wire [5:0] boe, bout, bpu, bin, bsy;
  wire [7:0] doe, dout, dpu, din, dsy;
  wire [12:0] alt;
  ppamux_top DUT (.clk(clk), .rstn(rstn), .portb_dir_bit(bdir), .portb_value_bit(bval),
    .portd_dir_bit(ddir), .portd_value_bit(dval), .spi_enable(c[10]), .spi_master(c[9]),
    .spi_sck_drive(c[8]), .spi_mosi_drive(c[7]), .spi_miso_drive(c[6]),
    .compare_match_enable(c[5]), .compare_match_out(c[4]), .uart_tx_enable(c[3]),
    .uart_tx_data(c[2]), .uart_rx_enable(c[1]), .power_down(c[0]), .portb_pin_in(bin),
    .portd_pin_in(din), .portb_pin_out(bout), .portb_pin_oe(boe), .portb_pullup(bpu),
    .portd_pin_out(dout), .portd_pin_oe(doe), .portd_pullup(dpu), .portb_sync_in(bsy),
    .portd_sync_in(dsy), .spi_sck_in(alt[12]), .spi_mosi_in(alt[11]), .spi_miso_in(alt[10]),
    .spi_slave_active(alt[9]), .capture_in(alt[8]), .capture_valid(alt[7]),
    .comparator_neg_valid(alt[6]), .comparator_pos_valid(alt[5]),
    .counter1_ext_source(alt[4]), .counter0_ext_source(alt[3]), .ext_irq_one(alt[2]),
    .ext_irq_zero(alt[1]), .uart_rx_data(alt[0]));
  ppamux_board #(.W(6)) u_bb (.oe(boe), .out(bout), .pu(bpu), .ext(bext), .ext_en(ben),
    .level(bin));
  ppamux_board #(.W(8)) u_db (.oe(doe), .out(dout), .pu(dpu), .ext(dext), .ext_en(den),
    .level(din));
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  function [7:0] lvl(input [7:0] oe, o, pu, x, e);
    lvl = (oe & o) | (~oe & e & x) | (~oe & ~e & (pu | ~x));
  endfunction
  task compare(input logic [63:0] e, input logic [63:0] g);
    n_tests = n_tests + 1;
    if (e !== g) begin
      fail_count = fail_count + 1;
      $display("Error at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task compare_pins(input logic [63:0] e, input logic [63:0] g);
    compare(e, g);
  endtask
  task compare_sync(input logic [63:0] e, input logic [63:0] g);
    compare(e, g);
  endtask
  task compare_alt(input logic [63:0] e, input logic [63:0] g);
    compare(e, g);
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // expected drive state mirrors what the pins see before each edge
  always @(posedge clk) begin
    s = c[10] & ~c[9];
    m = c[10] & c[9];
    if (!rstn) begin
      {xbo, xbv, xbp, hb0, hb1, xdo, xdv, xdp, hd0, hd1} = 0;
      run = 0;
    end else begin
      run = run + 1;
      if (run > 3) begin
        qs.push_back({hb0, hd0});
        qa.push_back({hb1[5], hb1[3], hb1[4], s & ~hb1[2], hb1[0], ~bdir[0],
          ~ddir[7] & ~dval[7], ~ddir[6] & ~dval[6], hd1[5:2], c[1] ? hd1[0] : 1'b1});
      end
      hb1 = hb0;
      hd1 = hd0;
      t8 = lvl(xbo, xbv, xbp, bext, ben);
      hb0 = t8[5:0];
      hd0 = lvl(xdo, xdv, xdp, dext, den) & ~{c[0], c[0], 6'h0};
      xbo = bdir & ~{s, m, s, s, 2'b00};
      xbv = bval;
      if (m) begin
        xbv[5] = c[8];
        xbv[3] = c[7];
      end
      if (s) xbv[4] = c[6];
      if (c[5] & bdir[1]) xbv[1] = c[4];
      xbv = xbv & xbo;
      xbp = ~xbo & bval;
      xdo = (ddir & ~{7'h0, c[1]}) | {6'h0, c[3], 1'b0};
      xdv = dval;
      if (c[3]) xdv[1] = c[2];
      xdv = xdv & xdo;
      xdp = ~xdo & dval;
      if (run > 3) qd.push_back({xbo, xbv, xbp, xdo, xdv, xdp});
    end
    repeat (11) r = lfsr(r);
    {ddir, dval, bdir, bval} <= r[27:0];
    repeat (11) r = lfsr(r);
    {ben, bext, c} <= r[22:0];
    repeat (11) r = lfsr(r);
    {den, dext} <= r[15:0];
  end
  always @(negedge clk)
    if (!rstn) begin
      qd.delete();
      qs.delete();
      qa.delete();
    end else if (qd.size() > 0) begin
      ed = qd.pop_front();
      compare_pins(ed[41:24], {boe, bout & boe, bpu});
      compare_pins(ed[23:0], {doe, dout & doe, dpu});
      compare_sync(qs.pop_front(), {bsy, dsy});
      compare_alt(qa.pop_front(), alt);
    end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fail_count = fail_count + 1;
      conclude;
    end
  end
  initial begin
    {bdir, bval, bext, ben, ddir, dval, dext, den, c} = 0;
    r = 32'h305a5361;
    {cyc, fail_count, n_tests, run} = 0;
    rstn = 0;
    repeat (12) @(posedge clk);
    rstn <= 1;
    repeat (2000) @(posedge clk);
    rstn <= 0;
    #1 compare_pins(0, {boe, doe, bpu, dpu});
    repeat (3) @(posedge clk);
    rstn <= 1;
    repeat (1000) @(posedge clk);
    conclude;
  end
endmodule
